// >>> tws_params.svh
// Constants of the two-wire register slave: addresses, regions, resets.
// Assumes inclusion by bare name from the design files.
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// ==========================================================
// Device address bytes, write and read
`define TWS_WADDR_MIPI 8'h6c
`define TWS_RADDR_MIPI 8'h6d
`define TWS_WADDR_CCP2 8'h20
`define TWS_RADDR_CCP2 8'h21

// ==========================================================
// Address space regions, upper nibble of the 16-bit address
`define TWS_RGN_CFG 4'h0
`define TWS_RGN_LIM 4'h1
`define TWS_RGN_MFR 4'h3
// Pages inside the manufacturer region
`define TWS_ALIAS_PAGE 4'h0
`define TWS_MFR_PAGE 4'h1
// Implemented bytes per storage page
`define TWS_PAGE_BYTES 256
// Read-only identity bytes at the bottom of configuration space
`define TWS_RO_BYTES 8'h02

// ==========================================================
// Reset values
`define TWS_PTR_RST 16'h0000
`define TWS_MEM_RST 8'h00

`endif

// >>> tws_pkg.sv
// Types shared by the two-wire register slave and its register store.
// Assumes tws_params.svh is compiled alongside.
package tws_pkg;

  // ========================================================
  // Protocol states of the serial engine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_OUT,
    ST_RX,
    ST_TX,
    ST_ACK_IN,
    ST_TX_LOAD,
    ST_IGNORE
  } tws_state_t;

  // ========================================================
  // One register access passed across the clock crossing
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tws_req_t;

  // ========================================================
  // Link-side state
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] sel_s;
    logic scl;
    logic sda;
    logic sel;
    tws_state_t state;
    logic [2:0] bitcnt;
    logic [7:0] sh;
    logic rw;
    logic ack_on;
    logic [1:0] wcnt;
    logic [15:0] ptr;
    logic oe;
    tws_req_t req;
    logic req_tgl;
    logic [1:0] ack_s;
    logic ack_seen;
    logic [7:0] rdata;
  } tws_link_t;

  // ========================================================
  // System-side state
  typedef struct packed {
    logic [1:0] req_s;
    logic req_seen;
    logic ack_tgl;
    logic [7:0] rdata;
  } tws_sys_t;

endpackage

// >>> tws_regs.sv
// Byte-wide register store with region decode and aliasing.
// Assumes one access per acc_en pulse, payload stable while it is high.
`timescale 1ns/1ps
`include "tws_params.svh"

module tws_regs #(
  parameter logic [15:0] MODEL_ID = 16'h0a5c, // Arbitrary identity value
  parameter logic [127:0] LIMITS = 128'h0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access port
  input wire logic acc_en,
  input wire tws_pkg::tws_req_t acc,
  output logic [7:0] rdata
);
  import tws_pkg::*;

  logic [7:0] cfg_mem [`TWS_PAGE_BYTES];
  logic [7:0] mfr_mem [`TWS_PAGE_BYTES];
  logic cfg_hit;
  logic mfr_hit;
  logic lim_hit;
  logic wr_ok;

  // ========================================================
  // Region decode, read mux and write qualification
  always_comb
  begin
    cfg_hit = (acc.addr[15:12] == `TWS_RGN_CFG && acc.addr[11:8] == 4'h0)
      || (acc.addr[15:12] == `TWS_RGN_MFR && acc.addr[11:8] == `TWS_ALIAS_PAGE);
    mfr_hit = acc.addr[15:12] == `TWS_RGN_MFR && acc.addr[11:8] == `TWS_MFR_PAGE;
    lim_hit = acc.addr[15:12] == `TWS_RGN_LIM && acc.addr[11:4] == 8'h00;
    rdata = 8'h00;
    if (cfg_hit)
      rdata = cfg_mem[acc.addr[7:0]];
    else if (mfr_hit)
      rdata = mfr_mem[acc.addr[7:0]];
    else if (lim_hit)
      rdata = LIMITS[{~acc.addr[3:0], 3'b111} -: 8];
    // Limits, statistics, identity and reserved bytes never take writes
    wr_ok = acc_en && acc.we
      && ((cfg_hit && acc.addr[7:0] >= `TWS_RO_BYTES) || mfr_hit);
  end

  // ========================================================
  // Byte storage; identity word is MSB first at the lower address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `TWS_PAGE_BYTES; i++)
      begin
        cfg_mem[i] <= `TWS_MEM_RST;
        mfr_mem[i] <= `TWS_MEM_RST;
      end
      cfg_mem[0] <= MODEL_ID[15:8];
      cfg_mem[1] <= MODEL_ID[7:0];
    end
    else if (wr_ok)
    begin
      if (cfg_hit)
        cfg_mem[acc.addr[7:0]] <= acc.wdata;
      else
        mfr_mem[acc.addr[7:0]] <= acc.wdata;
    end
  end

  // ========================================================
  // Checks
  alias_read_a: assert property (@(posedge clk) disable iff (rst)
    (acc.addr[15:8] == 8'h30) |-> rdata == cfg_mem[acc.addr[7:0]])
    else $error("alias read differs from configuration byte");
  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    (acc.addr[15:14] != 2'b00) |-> rdata == 8'h00)
    else $error("reserved address read nonzero");
  ro_write_a: assert property (@(posedge clk) disable iff (rst)
    (acc_en && acc.we && acc.addr[15:12] != `TWS_RGN_CFG
      && acc.addr[15:12] != `TWS_RGN_MFR)
    |=> $stable(cfg_mem[acc.addr[7:0]]) && $stable(mfr_mem[acc.addr[7:0]]))
    else $error("read-only write changed storage");
  id_fixed_a: assert property (@(posedge clk) disable iff (rst)
    (acc_en && acc.we) |=> $stable(cfg_mem[0]) && $stable(cfg_mem[1]))
    else $error("identity bytes changed by a write");
endmodule

// >>> tws_slave.sv
// Two-wire serial register slave: pin engine on link_clk, store on clk.
// Assumes link_clk runs freely and far faster than the serial clock.
// Function
// - Serial clock is input only; never pulled low, no stretching.
// - Start is data falling while clock high; repeated start allowed.
// - Stop is data rising while clock high; ends the transaction.
// - First byte: seven-bit address above, direction bit 0, one reads.
// - Address 0x6C/0x6D in MIPI setup, 0x20/0x21 in CCP2 setup.
// - Acknowledge address byte only when it equals own address.
// - Each byte is followed by one acknowledge slot from receiver.
// - Master refusal during read ends it; device releases data line.
// - Bytes move most significant bit first, eight bits each.
// - One bit per clock period; data changes only while clock low.
// - Internal pointer advances by one after each data byte.
// - Read without address phase uses the current pointer.
// - Write: address byte, pointer high, pointer low, then data.
// - Sequential writes store at successive addresses until stop.
// - Decode configuration, limits, statistics, maker and reserved; here statistics space is not decoded and reads zero like reserved.
// - Some configuration bytes also appear in maker space, same effect.
// - Storage is byte writable; wide registers naturally aligned.
// - Lowest address of a wide register holds its top byte.
// - Select pin low picks CCP2 setup, high picks MIPI setup.
// - Reset restores all registers and the address pointer.
`timescale 1ns/1ps
`include "tws_params.svh"

module tws_slave (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link oversampling clock
  input wire logic link_clk,
  // Serial clock, input only
  input wire logic scl_pin,
  // Serial data, open drain
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // Configuration select strap
  input wire logic cfg_sel_pin,
  // Status
  output logic link_busy
);
  import tws_pkg::*;

  // ========================================================
  // Declarations
  logic lrst_s1, lrst;
  tws_link_t lnk, next_lnk;
  tws_sys_t sys, next_sys;
  logic scl_new, sda_new;
  logic scl_rise, scl_fall;
  logic start_c, stop_c;
  logic [7:0] rx_byte, own_waddr;
  logic acc_go;
  logic [7:0] reg_rdata;

  // ========================================================
  // Link-domain reset: asserts at once, releases on link_clk
  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      {lrst, lrst_s1} <= 2'b11;
    else
      {lrst, lrst_s1} <= {lrst_s1, 1'b0};
  end

  // ========================================================
  // Filtered pin levels and bus events
  // Level moves once stages two and three agree: rejects glitches on slow edges
  assign scl_new = (lnk.scl_s[1] == lnk.scl_s[2]) ? lnk.scl_s[2] : lnk.scl;
  assign sda_new = (lnk.sda_s[1] == lnk.sda_s[2]) ? lnk.sda_s[2] : lnk.sda;
  assign scl_rise = scl_new & ~lnk.scl;
  assign scl_fall = ~scl_new & lnk.scl;
  assign start_c = lnk.scl & scl_new & lnk.sda & ~sda_new;
  assign stop_c = lnk.scl & scl_new & ~lnk.sda & sda_new;
  assign rx_byte = {lnk.sh[6:0], sda_new};
  // Strap high selects the MIPI address pair
  assign own_waddr = lnk.sel ? `TWS_WADDR_MIPI : `TWS_WADDR_CCP2;

  // ========================================================
  // Serial protocol engine, next-state logic
  always_comb
  begin
    next_lnk = lnk;
    next_lnk.scl_s = {lnk.scl_s[1:0], scl_pin};
    next_lnk.sda_s = {lnk.sda_s[1:0], serial_data_pin_in};
    next_lnk.sel_s = {lnk.sel_s[1:0], cfg_sel_pin};
    next_lnk.scl = scl_new;
    next_lnk.sda = sda_new;
    if (lnk.sel_s[1] == lnk.sel_s[2])
      next_lnk.sel = lnk.sel_s[2];
    // Read data returns by toggle; word is stable once it is seen
    next_lnk.ack_s = {lnk.ack_s[0], sys.ack_tgl};
    if (lnk.ack_s[1] != lnk.ack_seen)
    begin
      next_lnk.ack_seen = lnk.ack_s[1];
      next_lnk.rdata = sys.rdata;
    end
    unique case (lnk.state)
      ST_IDLE, ST_IGNORE:
        next_lnk.oe = 1'b0;
      ST_ADDR:
      begin
        if (scl_rise)
        begin
          next_lnk.sh = rx_byte;
          next_lnk.bitcnt = lnk.bitcnt + 3'd1;
          if (lnk.bitcnt == 3'd7)
          begin
            if (lnk.sh[6:0] == own_waddr[7:1])
            begin
              next_lnk.rw = sda_new;
              next_lnk.state = ST_ACK_OUT;
              if (sda_new)
              begin
                // Prefetch at the current pointer
                next_lnk.req = '{1'b0, lnk.ptr, 8'h00};
                next_lnk.req_tgl = ~lnk.req_tgl;
              end
            end
            else
              next_lnk.state = ST_IGNORE;
          end
        end
      end
      ST_ACK_OUT:
      begin
        // First fall pulls the line low, second fall ends the slot
        if (scl_fall)
        begin
          if (!lnk.ack_on)
          begin
            next_lnk.oe = 1'b1;
            next_lnk.ack_on = 1'b1;
          end
          else
          begin
            next_lnk.ack_on = 1'b0;
            next_lnk.bitcnt = 3'd0;
            if (lnk.rw)
            begin
              next_lnk.sh = lnk.rdata;
              next_lnk.oe = ~lnk.rdata[7];
              next_lnk.state = ST_TX;
            end
            else
            begin
              next_lnk.oe = 1'b0;
              next_lnk.state = ST_RX;
            end
          end
        end
      end
      ST_RX:
      begin
        if (scl_rise)
        begin
          next_lnk.sh = rx_byte;
          next_lnk.bitcnt = lnk.bitcnt + 3'd1;
          if (lnk.bitcnt == 3'd7)
          begin
            next_lnk.state = ST_ACK_OUT;
            unique case (lnk.wcnt)
              2'd0:
              begin
                next_lnk.ptr[15:8] = rx_byte;
                next_lnk.wcnt = 2'd1;
              end
              2'd1:
              begin
                next_lnk.ptr[7:0] = rx_byte;
                next_lnk.wcnt = 2'd2;
              end
              default:
              begin
                // Every data byte goes out as a write request and moves the pointer
                next_lnk.req = '{1'b1, lnk.ptr, rx_byte};
                next_lnk.req_tgl = ~lnk.req_tgl;
                next_lnk.ptr = lnk.ptr + 16'd1;
              end
            endcase
          end
        end
      end
      ST_TX:
      begin
        // Drive only after a fall so the line is steady while high
        if (scl_fall)
        begin
          next_lnk.sh = {lnk.sh[6:0], 1'b0};
          next_lnk.oe = ~lnk.sh[6];
        end
        if (scl_rise)
        begin
          next_lnk.bitcnt = lnk.bitcnt + 3'd1;
          if (lnk.bitcnt == 3'd7)
          begin
            next_lnk.state = ST_ACK_IN;
            next_lnk.ptr = lnk.ptr + 16'd1;
          end
        end
      end
      ST_ACK_IN:
      begin
        if (scl_fall)
          next_lnk.oe = 1'b0;
        if (scl_rise)
        begin
          if (!sda_new)
          begin
            next_lnk.req = '{1'b0, lnk.ptr, 8'h00};
            next_lnk.req_tgl = ~lnk.req_tgl;
            next_lnk.state = ST_TX_LOAD;
          end
          else
            next_lnk.state = ST_IGNORE;
        end
      end
      ST_TX_LOAD:
      begin
        // Fetch had the whole high phase of the slot to return
        if (scl_fall)
        begin
          next_lnk.sh = lnk.rdata;
          next_lnk.oe = ~lnk.rdata[7];
          next_lnk.bitcnt = 3'd0;
          next_lnk.state = ST_TX;
        end
      end
    endcase
    // Bus conditions override any byte in progress
    if (start_c)
    begin
      next_lnk.state = ST_ADDR;
      next_lnk.bitcnt = 3'd0;
      next_lnk.oe = 1'b0;
      next_lnk.wcnt = 2'd0;
      next_lnk.ack_on = 1'b0;
    end
    else if (stop_c)
    begin
      next_lnk.state = ST_IDLE;
      next_lnk.oe = 1'b0;
    end
  end

  // ========================================================
  // Link-domain state register; pointer returns to its default
  always_ff @(posedge link_clk or posedge lrst)
  begin
    if (lrst)
    begin
      lnk <= '0;
      lnk.ptr <= `TWS_PTR_RST;
      lnk.scl_s <= 3'b111; // Idle-high pins: no false edge once reset ends
      lnk.sda_s <= 3'b111;
      lnk.scl <= 1'b1;
      lnk.sda <= 1'b1;
    end
    else
      lnk <= next_lnk;
  end

  // ========================================================
  // System side: toggle handshake into the register store
  // Link side holds the payload until the next toggle; only the toggle is synchronised
  assign acc_go = sys.req_s[1] != sys.req_seen;
  always_comb
  begin
    next_sys = sys;
    next_sys.req_s = {sys.req_s[0], lnk.req_tgl};
    if (acc_go)
    begin
      next_sys.req_seen = sys.req_s[1];
      next_sys.ack_tgl = ~sys.ack_tgl;
      next_sys.rdata = reg_rdata;
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sys <= '0;
    else
      sys <= next_sys;
  end

  tws_regs u_regs (
    .clk(clk),
    .rst(rst),
    .acc_en(acc_go),
    .acc(lnk.req),
    .rdata(reg_rdata)
  );

  // ========================================================
  // Outputs: data line is only ever pulled low, clock never driven
  assign serial_data_pin_out = 1'b0;
  assign serial_data_pin_oe = lnk.oe;
  assign link_busy = lnk.state != ST_IDLE && lnk.state != ST_IGNORE;

  // ========================================================
  // Checks
  start_to_addr_a: assert property (@(posedge link_clk) disable iff (lrst)
    start_c |=> lnk.state == ST_ADDR && lnk.bitcnt == 3'd0 && !lnk.oe)
    else $error("start did not open address phase");
  stop_release_a: assert property (@(posedge link_clk) disable iff (lrst)
    stop_c |=> lnk.state == ST_IDLE && !serial_data_pin_oe)
    else $error("stop did not release bus");
  addr_mismatch_a: assert property (@(posedge link_clk) disable iff (lrst)
    (lnk.state == ST_ADDR && scl_rise && lnk.bitcnt == 3'd7 && !start_c
      && !stop_c && lnk.sh[6:0] != own_waddr[7:1]) |=> lnk.state == ST_IGNORE)
    else $error("mismatched address not ignored");
  ignore_quiet_a: assert property (@(posedge link_clk) disable iff (lrst)
    lnk.state == ST_IGNORE |-> !serial_data_pin_oe)
    else $error("line driven while ignoring");
  change_low_a: assert property (@(posedge link_clk) disable iff (lrst)
    ($changed(serial_data_pin_oe) && !$past(start_c) && !$past(stop_c))
      |-> !lnk.scl)
    else $error("data changed while clock high");
  nack_release_a: assert property (@(posedge link_clk) disable iff (lrst)
    (lnk.state == ST_ACK_IN && scl_rise && sda_new && !start_c && !stop_c)
      |=> lnk.state == ST_IGNORE ##1 !serial_data_pin_oe)
    else $error("refused read not ended");
  ptr_step_a: assert property (@(posedge link_clk) disable iff (lrst)
    (lnk.state == ST_TX && scl_rise && lnk.bitcnt == 3'd7 && !start_c && !stop_c)
      |=> lnk.ptr == $past(lnk.ptr) + 16'd1)
    else $error("pointer did not advance after byte");
  addr_sel_a: assert property (@(posedge link_clk) disable iff (lrst)
    (lnk.state == ST_ACK_OUT && $past(lnk.state) == ST_ADDR)
      |-> lnk.sh[7:1] == ($past(lnk.sel) ? 7'h36 : 7'h10))
    else $error("own address not set by strap");
endmodule

// >>> tws_master.sv
// Bus master model for the two-wire slave: drives clock, pulls data.
// Assumes a pull-up on the data wire and a bench that aligns calls.
`timescale 1ns/1ps
module tws_master (
  // Bus
  output logic scl,
  output logic sda_low,
  input wire logic sda,
  // Results seen by the master
  output logic ack_tgl,
  output logic ack_val,
  output logic rd_tgl,
  output logic [7:0] rd_byte
);
  int hp = 300;
  int q = 60;

  // ==========================================================
  // Idle bus, both lines high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack_tgl = 1'b0;
    ack_val = 1'b0;
    rd_tgl = 1'b0;
    rd_byte = 8'h00;
  end

  // Half period in 20 ns steps, always at least 300 ns
  task automatic set_hp(input int k);
    hp = 20 * k;
    q = 20 * (k / 4);
  endtask

  // ==========================================================
  // Bit level; data moves a while after the clock falls
  task automatic wbit(input logic b);
    #q sda_low = ~b;
    #(hp - q) scl = 1'b1;
    #hp scl = 1'b0;
  endtask

  // Release late so a rise is never mistaken for a stop
  task automatic rbit(output logic v);
    #q sda_low = 1'b0;
    #(hp - q) scl = 1'b1;
    #(hp / 2) v = sda;
    #(hp - hp / 2) scl = 1'b0;
  endtask

  // ==========================================================
  // Conditions, made by the master alone
  task automatic start();
    sda_low = 1'b0;
    #hp scl = 1'b1;
    #hp sda_low = 1'b1;
    #hp scl = 1'b0;
  endtask

  task automatic stop();
    #q sda_low = 1'b1;
    #(hp - q) scl = 1'b1;
    #hp sda_low = 1'b0;
    #hp;
  endtask

  // ==========================================================
  // Byte level, most significant bit first
  task automatic put_byte(input logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--)
      wbit(b[i]);
    rbit(v);
    ack_val = v;
    ack_tgl = ~ack_tgl;
  endtask

  // Acknowledge wanted bytes, refuse the last one
  task automatic get_byte(input logic more);
    logic v;
    for (int i = 7; i >= 0; i--)
    begin
      rbit(v);
      rd_byte[i] = v;
    end
    rd_tgl = ~rd_tgl;
    wbit(~more);
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the two-wire register slave.
// Assumes tws_master as bus partner and a pull-up on the data wire.
`timescale 1ns/1ps
module tb_top;
  import tws_pkg::*;
  localparam logic [15:0] ID = 16'h0a5c; // Arbitrary, the store default
  localparam logic [15:0] RGN [9] = '{16'h0000, 16'h00fe, 16'h00ff, 16'h1000,
    16'h2000, 16'h3000, 16'h31fe, 16'h4000, 16'hfffe};
  logic clk, rst, link_clk, cfg_sel_pin, scl, m_low, sda, oe, dout, busy;
  logic m_ack_tgl, m_ack_val, m_rd_tgl;
  logic [7:0] m_rd_byte, dev;
  logic [7:0] sh [0:511];
  logic [15:0] tptr;
  logic exp_ack [$];
  logic [7:0] exp_rd [$];
  int fails = 0, check_count = 0, cyc = 0;

  // Open-drain wire with pull-up
  assign sda = ~(m_low | (oe & ~dout));

  tws_master m (.scl(scl), .sda_low(m_low), .sda(sda), .ack_tgl(m_ack_tgl),
    .ack_val(m_ack_val), .rd_tgl(m_rd_tgl), .rd_byte(m_rd_byte));
  tws_slave dut (.clk(clk), .rst(rst), .link_clk(link_clk), .scl_pin(scl),
    .serial_data_pin_in(sda), .serial_data_pin_out(dout),
    .serial_data_pin_oe(oe), .cfg_sel_pin(cfg_sel_pin), .link_busy(busy));

  // ==========================================================
  // Clocks, link clock offset in phase
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  // ==========================================================
  // Shadow store with alias and region decode
  function automatic int idx(input logic [15:0] a);
    if (a[15:8] == 8'h00 || a[15:8] == 8'h30)
      return int'(a[7:0]);
    if (a[15:8] == 8'h31)
      return 256 + int'(a[7:0]);
    return -1;
  endfunction
  function automatic logic [7:0] rdexp(input logic [15:0] a);
    return idx(a) < 0 ? 8'h00 : sh[idx(a)];
  endfunction

  // ==========================================================
  // Comparison and closing
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h0, got}, {7'h0, exp});
  endtask
  task automatic finish_test();
    // Notes never answered count as mismatches too
    fails += exp_ack.size() + exp_rd.size();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic end_test(input string name);
    chk_bit(busy, 1'b0);
    $display("test %s done", name);
    m.set_hp(15 + $urandom % 10);
    @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // Bus sequences; each notes what the watchers must see
  task automatic reset_dut();
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    tptr = 16'h0000;
    foreach (sh[i])
      sh[i] = 8'h00;
    sh[0] = ID[15:8];
    sh[1] = ID[7:0];
    repeat (10) @(posedge clk);
    #1;
  endtask
  task automatic sb(input logic [7:0] b, input logic a);
    exp_ack.push_back(a);
    m.put_byte(b);
  endtask
  task automatic addr(input logic [15:0] a);
    m.start();
    sb(dev, 1'b0);
    sb(a[15:8], 1'b0);
    sb(a[7:0], 1'b0);
    chk_bit(busy, 1'b1);
    tptr = a;
  endtask
  task automatic wr(input logic [15:0] a, input int n);
    logic [7:0] b;
    addr(a);
    repeat (n)
    begin
      b = 8'($urandom);
      if (idx(tptr) >= 0 && (tptr[15:8] == 8'h31 || tptr[7:1] != 7'h0))
        sh[idx(tptr)] = b;
      tptr++;
      sb(b, 1'b0);
    end
    m.stop();
  endtask
  task automatic rd(input int n);
    m.start();
    sb(dev | 8'h01, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      exp_rd.push_back(rdexp(tptr));
      tptr++;
      m.get_byte(i < n - 1);
    end
    repeat (3) @(posedge clk);
    #1 chk_bit(oe, 1'b0);
    m.stop();
  endtask
  task automatic rrd(input logic [15:0] a, input int n);
    addr(a);
    rd(n);
  endtask

  // ==========================================================
  // Watchers, one per kind of result, oldest note first
  initial
  begin
    @(negedge rst);
    forever
    begin
      @(m_ack_tgl);
      if (exp_ack.size() == 0)
        chk_bit(m_ack_val, 1'bx);
      else
        chk_bit(m_ack_val, exp_ack.pop_front());
    end
  end
  initial
  begin
    @(negedge rst);
    forever
    begin
      @(m_rd_tgl);
      if (exp_rd.size() == 0)
        chk_byte(m_rd_byte, 8'hxx);
      else
        chk_byte(m_rd_byte, exp_rd.pop_front());
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fails++;
      finish_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    cfg_sel_pin = 1'b1;
    dev = 8'h6c;
    void'($urandom(761));
    reset_dut();
    rd(2);
    end_test("reset_read");
    wr(16'h0010, 4);
    rrd(16'h0010, 4);
    rd(1);
    end_test("sequential");
    wr(16'h3020, 2);
    rrd(16'h0020, 2);
    wr(16'h0021, 1);
    rrd(16'h3020, 2);
    end_test("alias");
    foreach (RGN[i])
    begin
      wr(RGN[i], 2);
      rrd(RGN[i], 2);
    end
    end_test("regions");
    m.start();
    sb(8'h6e, 1'b1);
    sb(8'h00, 1'b1);
    sb(8'h40, 1'b1);
    sb(8'h99, 1'b1);
    m.stop();
    rrd(16'h0040, 1);
    end_test("mismatch");
    cfg_sel_pin = 1'b0;
    dev = 8'h20;
    repeat (10) @(posedge clk);
    #1;
    m.start();
    sb(8'h6c, 1'b1);
    m.stop();
    rrd(16'h0010, 1);
    end_test("second_setup");
    cfg_sel_pin = 1'b1;
    dev = 8'h6c;
    repeat (10) @(posedge clk);
    #1;
    wr(16'h0050, 1);
    reset_dut();
    rd(1);
    rrd(16'h0050, 1);
    end_test("mid_reset");
    finish_test();
  end
endmodule
